// file: core/emc_params.svh
// constant definitions for the external memory bus control block
`ifndef EMC_PARAMS_SVH
`define EMC_PARAMS_SVH
`define EMC_WAIT_W 3
`define EMC_READY_MIN_WAITS 3'h2
`define EMC_WAIT_RESET 3'h0
`endif

// file: core/emc_pin_if.sv
// interface between access sequencer and pin mux
`timescale 1ns/100ps
`default_nettype none
interface emc_pin_if;
    logic prog_sel;
    logic data_sel;
    logic io_sel;
    logic mem_strb;
    logic io_strb;
    logic write;
    modport seq (output prog_sel, output data_sel, output io_sel, output mem_strb,
        output io_strb, output write);
    modport mux (input prog_sel, input data_sel, input io_sel, input mem_strb,
        input io_strb, input write);
endinterface : emc_pin_if
`default_nettype wire

// file: core/emc_pin_mux.sv
// pin mux: external-memory or host-port function, and output-off float
`timescale 1ns/100ps
`default_nettype none
module emc_pin_mux (
    emc_pin_if.mux bus,
    input wire logic host_port_mode,
    input wire logic off_n,
    input wire logic host_data_ready,
    input wire logic sub_a_gpio_bit3,
    input wire logic sub_a_gpio_oe_n,
    input wire logic sub_a_timer_out,
    input wire logic sub_a_timer_sel,
    input wire logic sub_b_gpio_bit3,
    input wire logic sub_b_gpio_oe_n,
    input wire logic sub_b_timer_out,
    input wire logic sub_b_timer_sel,
    output logic program_space_select_n,
    output logic program_space_select_oe_n,
    output logic data_space_select_n,
    output logic data_space_select_oe_n,
    output logic io_space_select_n,
    output logic io_space_select_oe_n,
    output logic mem_strobe_n,
    output logic mem_strobe_oe_n,
    output logic io_space_strobe_n,
    output logic io_space_strobe_oe_n,
    output logic rw_n,
    output logic rw_oe_n,
    output logic ready_out,
    output logic ready_oe_n
);
    logic ext_mode;
    assign ext_mode = !host_port_mode;
    // selects and strobes: in host mode the program and data selects turn into inputs
    always_comb
    begin
        program_space_select_n = !bus.prog_sel;
        data_space_select_n = !bus.data_sel;
        io_space_select_n = !bus.io_sel;
        mem_strobe_n = !(bus.mem_strb && ext_mode);
        io_space_strobe_n = !bus.io_strb;
        rw_n = !bus.write;
        ready_out = 1'b0;
        program_space_select_oe_n = !(ext_mode && off_n);
        data_space_select_oe_n = !(ext_mode && off_n);
        io_space_select_oe_n = !off_n;
        io_space_strobe_oe_n = !off_n;
        mem_strobe_oe_n = !(ext_mode && off_n);
        rw_oe_n = !(ext_mode && off_n);
        ready_oe_n = 1'b1;
        if (host_port_mode)
        begin
            ready_out = host_data_ready;
            ready_oe_n = !off_n;
            // gpio bit 3 or timer on the former io pins
            io_space_select_n = sub_b_timer_sel ? sub_b_timer_out : sub_b_gpio_bit3;
            io_space_select_oe_n = !off_n || (!sub_b_timer_sel && sub_b_gpio_oe_n);
            io_space_strobe_n = sub_a_timer_sel ? sub_a_timer_out : sub_a_gpio_bit3;
            io_space_strobe_oe_n = !off_n || (!sub_a_timer_sel && sub_a_gpio_oe_n);
        end
    end
endmodule : emc_pin_mux
`default_nettype wire

// file: core/emc_pkg.sv
// types shared by the external memory bus control block
package emc_pkg;
    typedef enum logic [1:0] {
        EMC_SPACE_PROG,
        EMC_SPACE_DATA,
        EMC_SPACE_IO
    } emc_space_t;
    typedef enum logic [1:0] {
        EMC_IDLE,
        EMC_WAIT,
        EMC_READY_CHECK,
        EMC_DONE
    } emc_state_t;
endpackage : emc_pkg

// file: core/emc_top.sv
// external memory bus control: access sequencer with wait states and ready
`timescale 1ns/100ps
`default_nettype none
`include "emc_params.svh"
module emc_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic host_port_mode,
    input wire logic off_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire emc_pkg::emc_space_t req_space,
    input wire logic req_write,
    input wire logic req_dma,
    input wire logic [`EMC_WAIT_W-1:0] req_waits,
    output logic done,
    input wire logic ready_in,
    input wire logic host_data_ready,
    input wire logic program_space_select_in,
    input wire logic data_space_select_in,
    input wire logic rw_in,
    output logic host_data_strobe_1,
    output logic host_data_strobe_2,
    output logic host_rw,
    input wire logic sub_a_gpio_bit3,
    input wire logic sub_a_gpio_oe_n,
    input wire logic sub_a_timer_out,
    input wire logic sub_a_timer_sel,
    input wire logic sub_b_gpio_bit3,
    input wire logic sub_b_gpio_oe_n,
    input wire logic sub_b_timer_out,
    input wire logic sub_b_timer_sel,
    output logic program_space_select_n,
    output logic program_space_select_oe_n,
    output logic data_space_select_n,
    output logic data_space_select_oe_n,
    output logic io_space_select_n,
    output logic io_space_select_oe_n,
    output logic mem_strobe_n,
    output logic mem_strobe_oe_n,
    output logic io_space_strobe_n,
    output logic io_space_strobe_oe_n,
    output logic rw_n,
    output logic rw_oe_n,
    output logic ready_out,
    output logic ready_oe_n
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    emc_pkg::emc_state_t state_reg;
    emc_pkg::emc_space_t space_reg;
    logic write_reg;
    logic dma_reg;
    logic check_ready_reg;
    logic [`EMC_WAIT_W-1:0] wait_reg;
    logic active;
    emc_pin_if pins ();

    // ready checking needs at least two wait states
    function automatic logic needs_ready(input logic [`EMC_WAIT_W-1:0] w);
        needs_ready = (w >= `EMC_READY_MIN_WAITS);
    endfunction : needs_ready

    // host mode blocks external accesses; pins belong to the host port
    assign req_ready = (state_reg == emc_pkg::EMC_IDLE) && !host_port_mode;
    assign active = (state_reg == emc_pkg::EMC_WAIT) ||
        (state_reg == emc_pkg::EMC_READY_CHECK);

    // state and captured request
    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= emc_pkg::EMC_IDLE;
            space_reg <= emc_pkg::EMC_SPACE_PROG;
            write_reg <= 1'b0;
            dma_reg <= 1'b0;
            check_ready_reg <= 1'b0;
            wait_reg <= `EMC_WAIT_RESET;
        end
        else
        begin
            case (state_reg)
                emc_pkg::EMC_IDLE:
                begin
                    if (req_valid && req_ready)
                    begin
                        space_reg <= req_space;
                        write_reg <= req_write;
                        dma_reg <= req_dma;
                        check_ready_reg <= needs_ready(req_waits);
                        wait_reg <= req_waits;
                        state_reg <= emc_pkg::EMC_WAIT;
                    end
                end
                emc_pkg::EMC_WAIT:
                begin
                    // one base cycle plus the programmed wait states
                    if (wait_reg != `EMC_WAIT_RESET)
                        wait_reg <= wait_reg - 3'h1;
                    else if (check_ready_reg && !ready_in)
                        state_reg <= emc_pkg::EMC_READY_CHECK;
                    else
                        state_reg <= emc_pkg::EMC_DONE;
                end
                emc_pkg::EMC_READY_CHECK:
                begin
                    // resample each cycle until the far end is ready
                    if (ready_in)
                        state_reg <= emc_pkg::EMC_DONE;
                end
                emc_pkg::EMC_DONE:
                    state_reg <= emc_pkg::EMC_IDLE;
                default:
                    state_reg <= emc_pkg::EMC_IDLE;
            endcase
        end
    end

    assign done = (state_reg == emc_pkg::EMC_DONE);

    // pin levels for the mux, held for the whole access
    always_comb
    begin
        pins.prog_sel = active && (space_reg == emc_pkg::EMC_SPACE_PROG);
        pins.data_sel = active && (space_reg == emc_pkg::EMC_SPACE_DATA);
        pins.io_sel = active && (space_reg == emc_pkg::EMC_SPACE_IO);
        pins.mem_strb = active && (space_reg != emc_pkg::EMC_SPACE_IO);
        // dma has its own io space, so it never strobes the external one
        pins.io_strb = active && (space_reg == emc_pkg::EMC_SPACE_IO) && !dma_reg;
        pins.write = active && write_reg;
    end

    // host port inputs taken from the shared pins
    assign host_data_strobe_1 = host_port_mode && program_space_select_in;
    assign host_data_strobe_2 = host_port_mode && data_space_select_in;
    assign host_rw = host_port_mode ? rw_in : 1'b1;

    emc_pin_mux u_mux (
        .bus(pins.mux),
        .host_port_mode(host_port_mode),
        .off_n(off_n),
        .host_data_ready(host_data_ready),
        .sub_a_gpio_bit3(sub_a_gpio_bit3),
        .sub_a_gpio_oe_n(sub_a_gpio_oe_n),
        .sub_a_timer_out(sub_a_timer_out),
        .sub_a_timer_sel(sub_a_timer_sel),
        .sub_b_gpio_bit3(sub_b_gpio_bit3),
        .sub_b_gpio_oe_n(sub_b_gpio_oe_n),
        .sub_b_timer_out(sub_b_timer_out),
        .sub_b_timer_sel(sub_b_timer_sel),
        .program_space_select_n(program_space_select_n),
        .program_space_select_oe_n(program_space_select_oe_n),
        .data_space_select_n(data_space_select_n),
        .data_space_select_oe_n(data_space_select_oe_n),
        .io_space_select_n(io_space_select_n),
        .io_space_select_oe_n(io_space_select_oe_n),
        .mem_strobe_n(mem_strobe_n),
        .mem_strobe_oe_n(mem_strobe_oe_n),
        .io_space_strobe_n(io_space_strobe_n),
        .io_space_strobe_oe_n(io_space_strobe_oe_n),
        .rw_n(rw_n),
        .rw_oe_n(rw_oe_n),
        .ready_out(ready_out),
        .ready_oe_n(ready_oe_n)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_stall;
        (state_reg == emc_pkg::EMC_READY_CHECK) && !ready_in;
    endsequence
    property p_ready_wait;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        s_stall |=> (state_reg == emc_pkg::EMC_READY_CHECK);
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready low did not stall");
    property p_ready_ignored;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        (state_reg == emc_pkg::EMC_WAIT) && !check_ready_reg |=>
            (state_reg != emc_pkg::EMC_READY_CHECK);
    endproperty
    a_ready_ignored: assert property (p_ready_ignored) else $error("ready checked");
    property p_prog_sel;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        active && space_reg == emc_pkg::EMC_SPACE_PROG && off_n && !host_port_mode |->
            !program_space_select_n && !program_space_select_oe_n;
    endproperty
    a_prog_sel: assert property (p_prog_sel) else $error("program select not driven");
    property p_data_sel;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        active && space_reg == emc_pkg::EMC_SPACE_DATA && off_n && !host_port_mode |->
            !data_space_select_n && !data_space_select_oe_n;
    endproperty
    a_data_sel: assert property (p_data_sel) else $error("data select not driven");
    property p_io_sel;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        active && space_reg == emc_pkg::EMC_SPACE_IO && off_n && !host_port_mode |->
            !io_space_select_n;
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("io select not driven");
    property p_float;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        !off_n |-> program_space_select_oe_n && data_space_select_oe_n &&
            io_space_select_oe_n && mem_strobe_oe_n && io_space_strobe_oe_n && rw_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("output not floated");
    property p_rw;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        !rw_n && !host_port_mode |-> active && write_reg;
    endproperty
    a_rw: assert property (p_rw) else $error("rw low outside a write");
    property p_dma_io;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        dma_reg && !host_port_mode |-> io_space_strobe_n;
    endproperty
    a_dma_io: assert property (p_dma_io) else $error("io strobe for dma");
    property p_wait_count;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        req_valid && req_ready && req_waits == 3'h2 |=>
            active [*3];
    endproperty
    a_wait_count: assert property (p_wait_count) else $error("strobe cut short");
    // the memory strobe belongs to external memory mode and program/data accesses
    property p_mem_strobe;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        !mem_strobe_n |-> !host_port_mode && active && (space_reg != emc_pkg::EMC_SPACE_IO);
    endproperty
    a_mem_strobe: assert property (p_mem_strobe) else $error("stray memory strobe");
    // a high ready in the resample state ends the access on the next edge
    property p_ready_go;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        (state_reg == emc_pkg::EMC_READY_CHECK) && ready_in |=> done;
    endproperty
    a_ready_go: assert property (p_ready_go) else $error("ready high did not finish");
    // three programmed waits hold the pins four cycles before ready counts
    sequence s_take_three;
        req_valid && req_ready && (req_waits == 3'h3);
    endsequence
    sequence s_held_four;
        active [*4];
    endsequence
    property p_wait_three;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        s_take_three |=> s_held_four;
    endproperty
    a_wait_three: assert property (p_wait_three) else $error("wait count cut short");
    // host mode: program/data select and direction pins become host port inputs, ready an output
    property p_host_strobe_1;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode |-> program_space_select_oe_n &&
            (host_data_strobe_1 == program_space_select_in);
    endproperty
    a_host_strobe_1: assert property (p_host_strobe_1) else $error("host pin driven");
    property p_host_strobe_2;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode |-> data_space_select_oe_n &&
            (host_data_strobe_2 == data_space_select_in);
    endproperty
    a_host_strobe_2: assert property (p_host_strobe_2) else $error("host pin driven");
    property p_host_ready;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode && off_n |-> !ready_oe_n && (ready_out == host_data_ready);
    endproperty
    a_host_ready: assert property (p_host_ready) else $error("ready pin not driven");
    property p_host_rw;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode |-> rw_oe_n && (host_rw == rw_in);
    endproperty
    a_host_rw: assert property (p_host_rw) else $error("rw pin driven");
    // host mode: the io pins carry the subsystem timers when selected
    property p_sub_b_timer;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode && off_n && sub_b_timer_sel |->
            !io_space_select_oe_n && (io_space_select_n == sub_b_timer_out);
    endproperty
    a_sub_b_timer: assert property (p_sub_b_timer) else $error("timer b missing");
    property p_sub_a_timer;
        @(posedge sys_clk) disable iff (!rst_n_reg)
        host_port_mode && off_n && sub_a_timer_sel |->
            !io_space_strobe_oe_n && (io_space_strobe_n == sub_a_timer_out);
    endproperty
    a_sub_a_timer: assert property (p_sub_a_timer) else $error("timer a missing");
endmodule : emc_top
`default_nettype wire

// file: sim/emc_ext_dev.sv
// external memory or peripheral model that answers on the ready pin
`timescale 1ns/100ps
`default_nettype none
module emc_ext_dev (
    input wire logic sys_clk,
    input wire logic prog_sel_n,
    input wire logic data_sel_n,
    input wire logic io_sel_n,
    input wire logic [2:0] stall,
    output logic ready_drv
);
    // ------------------------------------------------------------
    // access age and ready answer
    // ------------------------------------------------------------
    logic [3:0] age_reg = 4'h0;
    logic idle_pat_reg = 1'h0;
    logic active;

    assign active = !(prog_sel_n && data_sel_n && io_sel_n);

    // age restarts when every select is released
    always @(posedge sys_clk)
    begin
        age_reg <= active ? age_reg + 4'h1 : 4'h0;
        idle_pat_reg <= !idle_pat_reg;
    end

    // outside an access the level toggles, so a stale ready never helps
    assign ready_drv = active ? (age_reg >= {1'h0, stall}) : idle_pat_reg;
endmodule : emc_ext_dev
`default_nettype wire

// file: sim/external_memory_bus_control_tb.sv
// self-checking bench for the external memory bus control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module external_memory_bus_control_tb;
    // ------------------------------------------------------------
    // stimulus, pins and instances
    // ------------------------------------------------------------
    logic sys_clk = 1'h0;
    logic resetn = 1'h0, host_port_mode = 1'h0, off_n = 1'h1, req_valid = 1'h0;
    logic req_write = 1'h0, req_dma = 1'h0, host_data_ready = 1'h0;
    logic host_pin_1 = 1'h1, host_pin_2 = 1'h1, host_wr = 1'h1;
    logic sub_a_gpio_bit3 = 1'h0, sub_a_gpio_oe_n = 1'h1, sub_a_timer_out = 1'h0;
    logic sub_b_gpio_bit3 = 1'h0, sub_b_gpio_oe_n = 1'h1, sub_b_timer_out = 1'h0;
    logic sub_a_timer_sel = 1'h0, sub_b_timer_sel = 1'h0;
    logic [2:0] req_waits = 3'h0, stall = 3'h0;
    emc_pkg::emc_space_t req_space = emc_pkg::EMC_SPACE_PROG;
    logic req_ready, done, host_data_strobe_1, host_data_strobe_2, host_rw, dev_ready;
    logic program_space_select_n, program_space_select_oe_n;
    logic data_space_select_n, data_space_select_oe_n, io_space_select_n;
    logic io_space_select_oe_n, mem_strobe_n, mem_strobe_oe_n, io_space_strobe_n;
    logic io_space_strobe_oe_n, rw_n, rw_oe_n, ready_out, ready_oe_n, io_wire;
    logic ready_in, program_space_select_in, data_space_select_in, rw_in;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'ha0e9;

    always #10 sys_clk = ~sys_clk;

    // each shared pin resolves from whoever drives it; only the io select wire is pulled up when floating
    assign program_space_select_in = program_space_select_oe_n ? host_pin_1 :
        program_space_select_n;
    assign data_space_select_in = data_space_select_oe_n ? host_pin_2 : data_space_select_n;
    assign rw_in = rw_oe_n ? host_wr : rw_n;
    assign ready_in = ready_oe_n ? dev_ready : ready_out;
    assign io_wire = io_space_select_oe_n ? 1'h1 : io_space_select_n;

    emc_top uut (.*);
    emc_ext_dev dev (.sys_clk(sys_clk), .prog_sel_n(program_space_select_in),
        .data_sel_n(data_space_select_in), .io_sel_n(io_wire), .stall(stall),
        .ready_drv(dev_ready));

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // one access; the model length is waits+2 plus every low ready sample when waits are two or more
    task run_access(input emc_pkg::emc_space_t sp, input logic wr, input logic dm,
        input logic [2:0] w, input logic [2:0] st);
        int exp_len;
        int len;
        exp_len = int'(w) + 2 + ((w >= 3'h2 && st > w) ? int'(st - w) : 0);
        @(negedge sys_clk);
        req_valid = 1'h1;
        req_space = sp;
        req_write = wr;
        req_dma = dm;
        req_waits = w;
        stall = st;
        @(negedge sys_clk);
        req_valid = 1'h0;
        len = 1;
        while (done !== 1'h1 && len < 40)
        begin
            `CHK(program_space_select_n, sp != emc_pkg::EMC_SPACE_PROG)
            `CHK(data_space_select_n, sp != emc_pkg::EMC_SPACE_DATA)
            if (!dm) `CHK(io_space_select_n, sp != emc_pkg::EMC_SPACE_IO)
            `CHK(mem_strobe_n, sp == emc_pkg::EMC_SPACE_IO)
            `CHK(io_space_strobe_n, !(sp == emc_pkg::EMC_SPACE_IO && !dm))
            `CHK({rw_n, req_ready}, {!wr, 1'h0})
            @(negedge sys_clk);
            len++;
        end
        `CHK(len, exp_len)
        `CHK(program_space_select_n & data_space_select_n & mem_strobe_n & rw_n, 1'h1)
    endtask : run_access

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge sys_clk);
        resetn = 1'h1;
        repeat (3) @(negedge sys_clk);
        `CHK({req_ready, rw_n}, 2'h3)
        // pin sharing and float, with the mode and off input shuffled
        repeat (24)
        begin
            rnd = lfsr_step(rnd);
            {host_port_mode, off_n, host_data_ready, host_pin_1, host_pin_2, host_wr} = rnd[5:0];
            {sub_a_gpio_bit3, sub_a_gpio_oe_n, sub_a_timer_out, sub_a_timer_sel} = rnd[9:6];
            {sub_b_gpio_bit3, sub_b_gpio_oe_n, sub_b_timer_out, sub_b_timer_sel} = rnd[13:10];
            #5;
            if (!off_n)
            begin
                `CHK({program_space_select_oe_n, data_space_select_oe_n, io_space_select_oe_n,
                    mem_strobe_oe_n, io_space_strobe_oe_n, rw_oe_n}, 6'h3f)
            end
            else if (host_port_mode)
            begin
                `CHK({host_data_strobe_1, program_space_select_oe_n}, {host_pin_1, 1'h1})
                `CHK({host_data_strobe_2, data_space_select_oe_n}, {host_pin_2, 1'h1})
                `CHK({ready_oe_n, ready_out}, {1'h0, host_data_ready})
                `CHK({rw_oe_n, host_rw}, {1'h1, host_wr})
                `CHK(io_space_select_oe_n, sub_b_timer_sel ? 1'h0 : sub_b_gpio_oe_n)
                if (!io_space_select_oe_n)
                    `CHK(io_space_select_n,
                        sub_b_timer_sel ? sub_b_timer_out : sub_b_gpio_bit3)
                `CHK(io_space_strobe_oe_n, sub_a_timer_sel ? 1'h0 : sub_a_gpio_oe_n)
                if (!io_space_strobe_oe_n)
                    `CHK(io_space_strobe_n,
                        sub_a_timer_sel ? sub_a_timer_out : sub_a_gpio_bit3)
                `CHK({mem_strobe_oe_n, req_ready}, 2'h2)
            end
            else
            begin
                `CHK({ready_oe_n, host_data_strobe_1, host_data_strobe_2, host_rw}, 4'h9)
                `CHK({program_space_select_oe_n, mem_strobe_oe_n, rw_oe_n,
                    program_space_select_n, mem_strobe_n, rw_n}, 6'h07)
            end
            @(negedge sys_clk);
        end
        host_port_mode = 1'h0;
        off_n = 1'h1;
        // boundary cases first, then random traffic with a stalling device
        run_access(emc_pkg::EMC_SPACE_DATA, 1'h1, 1'h0, 3'h1, 3'h7);
        run_access(emc_pkg::EMC_SPACE_PROG, 1'h0, 1'h0, 3'h2, 3'h6);
        run_access(emc_pkg::EMC_SPACE_IO, 1'h1, 1'h1, 3'h7, 3'h0);
        run_access(emc_pkg::EMC_SPACE_DATA, 1'h0, 1'h0, 3'h3, 3'h5);
        repeat (40)
        begin
            rnd = lfsr_step(rnd);
            run_access(emc_pkg::emc_space_t'(rnd[1:0] == 2'h3 ? 2'h0 : rnd[1:0]),
                rnd[2], rnd[3], rnd[6:4], rnd[9:7]);
        end
        final_report;
    end

    // the whole run needs well under a thousand cycles; allow twenty times that
    initial
    begin
        #400_000;
        n_mismatch++;
        final_report;
    end
endmodule : external_memory_bus_control_tb
`default_nettype wire
